// File: hdl/fpm_top.sv
`timescale 1ns/1ns
// Function
// - lockout on ignores all panel presses and lights remote-only LED.
// - clock, position and frame switches held together end lockout.
// - set in time code display moves to parameter name.
// - set in name display moves to that parameter's value.
// - set in value display commits value, returns to time code.
// - down/up in name display step through parameter list.
// - down/up in value display step through permitted range.
// - down+up together during time code entry cycles entry field.
// - run in time code display toggles generator running in generator-preset mode.
// - run in time code display, generator mode off, clears counter.
// - run elsewhere cancels the edit without committing.
// - holding up or down repeats the step automatically.
// - name display opens at generator preset or last used.
// - output level steps by a fixed 3 dBu increment.
// - lockout, firmware, burn window, gpio, varispeed not in menu.
// - output level clamps at -24 dBu and +9 dBu.
module fpm_top
  import fpm_pkg::*;
#(
  parameter int       DB_CYCLES  = DB_CYC,
  parameter int       RPT_DELAY  = RPT_DELAY_CYC,
  parameter int       RPT_RATE   = RPT_RATE_CYC,
  parameter int       NUM_PARAMS = 16,
  parameter bit [7:0] PARAM_MAX  = VAL_MAX
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        set_sw_i,
  input  wire logic        down_sw_i,
  input  wire logic        up_sw_i,
  input  wire logic        run_sw_i,
  input  wire logic        clk_ref_sw_i,
  input  wire logic        pos_ref_sw_i,
  input  wire logic        frame_sw_i,
  output logic      [1:0]  disp_state_o,
  output logic      [3:0]  disp_idx_o,
  output logic      [7:0]  disp_value_o,
  output logic      [1:0]  tc_field_o,
  output logic             gen_run_o,
  output logic             counter_clear_o,
  output logic             remote_only_led_o,
  output logic             clk_ref_press_o,
  output logic             pos_ref_press_o,
  output logic             frame_press_o
);

  // ***********************************************************
  // declarations
  // ***********************************************************
  localparam logic [CNT_W-1:0] DLY_LIM = CNT_W'(RPT_DELAY - 1);
  localparam logic [CNT_W-1:0] RATE_LIM = CNT_W'(RPT_RATE - 1);
  localparam logic [IDX_W-1:0] IDX_MAX = IDX_W'(NUM_PARAMS - 1);

  logic [NUM_SW-1:0] sw_raw;
  logic [NUM_SW-1:0] sw_lvl;
  logic [NUM_SW-1:0] sw_rise;
  logic [NUM_SW-1:0] act;
  logic              chord;
  logic              held;
  logic              up_step;
  logic              dn_step;
  logic              fld_step;
  logic              wr_ctrl;

  fpm_state_e        state_reg;
  logic [IDX_W-1:0]  idx_reg;
  logic [IDX_W-1:0]  last_reg;
  logic [7:0]        edit_reg;
  logic [7:0]        edit_next;
  logic [31:0]       edit_tc_reg;
  logic [31:0]       edit_tc_next;
  logic [1:0]        fld_reg;
  logic [31:0]       preset_reg;
  logic [7:0]        val_mem [NUM_PARAMS];
  logic              lock_reg;
  logic              gen_mode_reg;
  logic              last_en_reg;
  logic              run_reg;
  logic              clr_reg;
  logic [CNT_W-1:0]  rpt_cnt_reg;
  logic              rpt_first_reg;
  logic              rpt_reg;
  logic              wr_pend_reg;
  logic [7:0]        addr_reg;
  logic [31:0]       rdata_reg;
  logic [7:0]        disp_reg;
  logic [2:0]        press_reg;

  // ***********************************************************
  // switch conditioning
  // ***********************************************************
  assign sw_raw = {frame_sw_i, pos_ref_sw_i, clk_ref_sw_i, run_sw_i,
                   up_sw_i, down_sw_i, set_sw_i};

  fpm_debounce #(
    .N         (NUM_SW),
    .DB_CYCLES (DB_CYCLES)
  ) u_debounce (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (sw_raw),
    .level_o (sw_lvl),
    .rise_o  (sw_rise)
  );

  // presses are dropped while locked
  assign act = sw_rise & {NUM_SW{~lock_reg}};
  assign chord = sw_lvl[SW_CLK] & sw_lvl[SW_POS] & sw_lvl[SW_FRM];
  assign held = ~lock_reg & (sw_lvl[SW_UP] ^ sw_lvl[SW_DN]);

  assign fld_step = (act[SW_UP] & sw_lvl[SW_DN])
                  | (act[SW_DN] & sw_lvl[SW_UP]);
  assign up_step = (act[SW_UP] & ~sw_lvl[SW_DN])
                 | (rpt_reg & held & sw_lvl[SW_UP]);
  assign dn_step = (act[SW_DN] & ~sw_lvl[SW_UP])
                 | (rpt_reg & held & sw_lvl[SW_DN]);

  // ***********************************************************
  // auto repeat
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rpt_cnt_reg   <= '0;
      rpt_first_reg <= 1'b1;
      rpt_reg       <= 1'b0;
    end else begin
      rpt_reg <= 1'b0;
      if (!held) begin
        rpt_cnt_reg   <= '0;
        rpt_first_reg <= 1'b1;
      end else if (rpt_cnt_reg == (rpt_first_reg ? DLY_LIM : RATE_LIM))
      begin
        rpt_cnt_reg   <= '0;
        rpt_first_reg <= 1'b0;
        rpt_reg       <= 1'b1;
      end else begin
        rpt_cnt_reg <= rpt_cnt_reg + 1'b1;
      end
    end
  end

  // ***********************************************************
  // lockout and control bits
  // ***********************************************************
  assign wr_ctrl = wr_pend_reg && (addr_reg == CTRL_ADDR);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_reg <= LOCK_RST;
    end else if (chord) begin
      lock_reg <= 1'b0;
    end else if (wr_ctrl) begin
      lock_reg <= hwdata_i[CTRL_LOCK];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_mode_reg <= GEN_RST;
      last_en_reg  <= LAST_RST;
    end else if (wr_ctrl) begin
      gen_mode_reg <= hwdata_i[CTRL_GEN];
      last_en_reg  <= hwdata_i[CTRL_LAST];
    end
  end

  // ***********************************************************
  // display state machine
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= FPM_TC;
    end else begin
      unique case (state_reg)
        FPM_TC: begin
          if (act[SW_SET]) begin
            state_reg <= FPM_NAME;
          end
        end
        FPM_NAME: begin
          if (act[SW_SET]) begin
            state_reg <= FPM_VALUE;
          end else if (act[SW_RUN]) begin
            state_reg <= FPM_TC;
          end
        end
        FPM_VALUE: begin
          if (act[SW_SET]) begin
            state_reg <= FPM_TC;
          end else if (act[SW_RUN]) begin
            state_reg <= FPM_TC;
          end
        end
      endcase
    end
  end

  // ***********************************************************
  // parameter selection
  // ***********************************************************
  // the menu list holds only panel parameters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_reg  <= GEN_IDX;
      last_reg <= GEN_IDX;
    end else if (state_reg == FPM_TC && act[SW_SET]) begin
      idx_reg <= last_en_reg ? last_reg : GEN_IDX;
    end else if (state_reg == FPM_NAME) begin
      if (up_step) begin
        idx_reg <= (idx_reg == IDX_MAX) ? GEN_IDX
                                        : idx_reg + 1'b1;
      end else if (dn_step) begin
        idx_reg <= (idx_reg == GEN_IDX) ? IDX_MAX
                                        : idx_reg - 1'b1;
      end
    end else if (state_reg == FPM_VALUE && act[SW_SET]) begin
      last_reg <= idx_reg;
    end
  end

  // ***********************************************************
  // value editing
  // ***********************************************************
  function automatic logic [7:0] fld_max(input logic [1:0] f);
    logic [7:0] m;
    m = MS_MAX;
    if (f == FLD_HH) begin
      m = HH_MAX;
    end else if (f == FLD_FF) begin
      m = FF_MAX;
    end
    return m;
  endfunction

  always_comb begin
    logic [7:0] fv;
    fv           = edit_tc_reg[fld_reg*8 +: 8];
    edit_next    = edit_reg;
    edit_tc_next = edit_tc_reg;
    if (idx_reg == GEN_IDX) begin
      if (up_step) begin
        fv = (fv >= fld_max(fld_reg)) ? 8'h00 : fv + 8'h01;
      end else if (dn_step) begin
        fv = (fv == 8'h00) ? fld_max(fld_reg) : fv - 8'h01;
      end
      edit_tc_next[fld_reg*8 +: 8] = fv;
    end else if (idx_reg == LEVEL_IDX) begin
      if (up_step && $signed(edit_reg) <= LVL_MAX - LVL_STEP) begin
        edit_next = edit_reg + LVL_STEP;
      end else if (dn_step && $signed(edit_reg) >= LVL_MIN + LVL_STEP)
      begin
        edit_next = edit_reg - LVL_STEP;
      end
    end else begin
      if (up_step) begin
        edit_next = (edit_reg >= PARAM_MAX) ? 8'h00
                                            : edit_reg + 8'h01;
      end else if (dn_step) begin
        edit_next = (edit_reg == 8'h00) ? PARAM_MAX
                                        : edit_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edit_reg    <= VAL_RST;
      edit_tc_reg <= TC_RST;
      fld_reg     <= FLD_HH;
    end else if (state_reg == FPM_NAME && act[SW_SET]) begin
      edit_reg    <= val_mem[idx_reg];
      edit_tc_reg <= preset_reg;
      fld_reg     <= FLD_HH;
    end else if (state_reg == FPM_VALUE) begin
      if (fld_step && idx_reg == GEN_IDX) begin
        fld_reg <= fld_reg + 2'h1;
      end else begin
        edit_reg    <= edit_next;
        edit_tc_reg <= edit_tc_next;
      end
    end
  end

  // ***********************************************************
  // committed settings
  // ***********************************************************
  genvar p;
  generate
    for (p = 0; p < NUM_PARAMS; p++) begin : g_val
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          val_mem[p] <= VAL_RST;
        end else if (state_reg == FPM_VALUE && act[SW_SET]
                     && idx_reg == IDX_W'(p)) begin
          val_mem[p] <= edit_reg;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preset_reg <= TC_RST;
    end else if (state_reg == FPM_VALUE && act[SW_SET]
                 && idx_reg == GEN_IDX) begin
      preset_reg <= edit_tc_reg;
    end
  end

  // ***********************************************************
  // generator run and counter clear
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= 1'b0;
      clr_reg <= 1'b0;
    end else begin
      clr_reg <= 1'b0;
      if (state_reg == FPM_TC && act[SW_RUN]) begin
        if (gen_mode_reg) begin
          run_reg <= ~run_reg;
        end else begin
          clr_reg <= 1'b1;
        end
      end
    end
  end

  // ***********************************************************
  // panel outputs
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disp_reg  <= 8'h00;
      press_reg <= 3'h0;
    end else begin
      press_reg <= act[SW_FRM:SW_CLK];
      unique case (state_reg)
        FPM_TC:    disp_reg <= 8'h00;
        FPM_NAME:  disp_reg <= 8'(idx_reg);
        FPM_VALUE: disp_reg <= (idx_reg == GEN_IDX)
                               ? edit_tc_reg[fld_reg*8 +: 8] : edit_reg;
        default:   disp_reg <= 8'h00;
      endcase
    end
  end

  assign disp_state_o      = state_reg;
  assign disp_idx_o        = idx_reg;
  assign disp_value_o      = disp_reg;
  assign tc_field_o        = fld_reg;
  assign gen_run_o         = run_reg;
  assign counter_clear_o   = clr_reg;
  assign remote_only_led_o = lock_reg;
  assign clk_ref_press_o   = press_reg[0];
  assign pos_ref_press_o   = press_reg[1];
  assign frame_press_o     = press_reg[2];

  // ***********************************************************
  // bus slave
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      rdata_reg   <= 32'h0000_0000;
    end else if (hready_i) begin
      wr_pend_reg <= hsel_i & htrans_i[1] & hwrite_i;
      addr_reg    <= haddr_i[7:0];
      rdata_reg   <= 32'h0000_0000;
      if (hsel_i && htrans_i[1] && !hwrite_i) begin
        unique case (haddr_i[7:0])
          CTRL_ADDR:   rdata_reg <= 32'({last_en_reg, gen_mode_reg,
                                         lock_reg});
          STAT_ADDR:   rdata_reg <= 32'({fld_reg, idx_reg, run_reg,
                                         lock_reg, state_reg});
          LEVEL_ADDR:  rdata_reg <= 32'(val_mem[LEVEL_IDX]);
          PRESET_ADDR: rdata_reg <= preset_reg;
          EDIT_ADDR:   rdata_reg <= 32'({edit_tc_reg[23:0], edit_reg});
          default:     rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign hrdata_o    = rdata_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

endmodule

// File: hdl/fpm_pkg.sv
package fpm_pkg;

  // ***********************************************************
  // clock and switch timing
  // ***********************************************************
  localparam int CLK_KHZ       = 10000;
  localparam int DB_TIME_MS    = 5;
  localparam int DB_CYC        = DB_TIME_MS * CLK_KHZ;
  localparam int RPT_DELAY_MS  = 500;
  localparam int RPT_DELAY_CYC = RPT_DELAY_MS * CLK_KHZ;
  localparam int RPT_RATE_MS   = 100;
  localparam int RPT_RATE_CYC  = RPT_RATE_MS * CLK_KHZ;
  localparam int CNT_W         = 24;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STAT_ADDR   = 8'h04;
  localparam logic [7:0] LEVEL_ADDR  = 8'h08;
  localparam logic [7:0] PRESET_ADDR = 8'h0C;
  localparam logic [7:0] EDIT_ADDR   = 8'h10;
  localparam int         CTRL_LOCK   = 0;
  localparam int         CTRL_GEN    = 1;
  localparam int         CTRL_LAST   = 2;
  localparam logic       LOCK_RST    = 1'h0;
  localparam logic       GEN_RST     = 1'h0;
  localparam logic       LAST_RST    = 1'h0;

  // ***********************************************************
  // parameter list and value ranges
  // ***********************************************************
  localparam int               IDX_W     = 4;
  localparam logic [IDX_W-1:0] GEN_IDX   = 4'h0;
  localparam logic [IDX_W-1:0] LEVEL_IDX = 4'h1;
  localparam logic [IDX_W-1:0] IDX_LAST  = 4'hF;
  localparam logic [7:0]       VAL_MAX   = 8'h0F;
  localparam logic [7:0]       VAL_RST   = 8'h00;
  localparam logic signed [7:0] LVL_MIN  = -8'sh18;
  localparam logic signed [7:0] LVL_MAX  = 8'sh09;
  localparam logic signed [7:0] LVL_STEP = 8'sh03;
  localparam logic [31:0]      TC_RST    = 32'h0000_0000;
  localparam logic [7:0]       HH_MAX    = 8'h17;
  localparam logic [7:0]       MS_MAX    = 8'h3B;
  localparam logic [7:0]       FF_MAX    = 8'h1D;
  localparam logic [1:0]       FLD_HH    = 2'h0;
  localparam logic [1:0]       FLD_FF    = 2'h3;

  // ***********************************************************
  // switches and display states
  // ***********************************************************
  localparam int NUM_SW = 7;
  localparam int SW_SET = 0;
  localparam int SW_DN  = 1;
  localparam int SW_UP  = 2;
  localparam int SW_RUN = 3;
  localparam int SW_CLK = 4;
  localparam int SW_POS = 5;
  localparam int SW_FRM = 6;

  typedef enum logic [1:0] {
    FPM_TC,
    FPM_NAME,
    FPM_VALUE
  } fpm_state_e;

endpackage

// File: hdl/fpm_debounce.sv
`timescale 1ns/1ns
module fpm_debounce
  import fpm_pkg::*;
#(
  parameter int N         = NUM_SW,
  parameter int DB_CYCLES = DB_CYC
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] raw_i,
  output logic      [N-1:0] level_o,
  output logic      [N-1:0] rise_o
);

  // ***********************************************************
  // per-switch stability counter
  // ***********************************************************
  localparam logic [CNT_W-1:0] LIM = CNT_W'(DB_CYCLES - 1);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sw
      logic [CNT_W-1:0] cnt_reg;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_reg    <= '0;
          level_o[g] <= 1'b0;
          rise_o[g]  <= 1'b0;
        end else begin
          rise_o[g] <= 1'b0;
          if (raw_i[g] == level_o[g]) begin
            cnt_reg <= '0;
          end else if (cnt_reg == LIM) begin
            // one stable change to pressed gives one press edge; a release gives none
            cnt_reg    <= '0;
            level_o[g] <= raw_i[g];
            rise_o[g]  <= raw_i[g];
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      end
    end
  endgenerate

endmodule

// File: tb/fpm_top_monitor.sv
`timescale 1ns/1ns
module fpm_top_monitor
  import fpm_pkg::*;
#(
  parameter int DB_CYCLES = DB_CYC
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       clk_ref_sw_i,
  input wire logic       pos_ref_sw_i,
  input wire logic       frame_sw_i,
  input wire logic [1:0] disp_state_o,
  input wire logic [3:0] disp_idx_o,
  input wire logic [7:0] disp_value_o,
  input wire logic [1:0] tc_field_o,
  input wire logic       gen_run_o,
  input wire logic       counter_clear_o,
  input wire logic       remote_only_led_o,
  input wire logic       clk_ref_press_o,
  input wire logic       pos_ref_press_o,
  input wire logic       frame_press_o
);
  // ***********************************************************
  // helpers
  // ***********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] chord_cnt;

  // consecutive cycles with all three reference switches held
  always_ff @(posedge clk_i) begin
    if (rst_i || !(clk_ref_sw_i && pos_ref_sw_i && frame_sw_i)) begin
      chord_cnt <= 16'h0000;
    end else if (chord_cnt != 16'hFFFF) begin
      chord_cnt <= chord_cnt + 16'h0001;
    end
  end

  sequence s_tc_idle;
    disp_state_o == FPM_TC && !gen_run_o;
  endsequence
  sequence s_level_shown;
    disp_state_o == FPM_VALUE && disp_idx_o == LEVEL_IDX &&
      $past(disp_state_o) == FPM_VALUE;
  endsequence

  // ***********************************************************
  // assertions
  // ***********************************************************
  a_lock_freeze: assert property (
    remote_only_led_o && $past(remote_only_led_o) |->
      $stable(disp_state_o) && $stable(gen_run_o) && !counter_clear_o)
    else $error("state moved while locked");
  a_lock_quiet: assert property (
    remote_only_led_o && $past(remote_only_led_o) |->
      !(clk_ref_press_o || pos_ref_press_o || frame_press_o))
    else $error("reference press while locked");
  a_chord_exit: assert property (
    chord_cnt > DB_CYCLES + 2 |-> !remote_only_led_o)
    else $error("chord did not end lockout");
  a_tc_to_name: assert property (
    $changed(disp_state_o) && $past(disp_state_o) == FPM_TC |->
      disp_state_o == FPM_NAME)
    else $error("time code left to wrong state");
  a_value_exit: assert property (
    $changed(disp_state_o) && $past(disp_state_o) == FPM_VALUE |->
      disp_state_o == FPM_TC)
    else $error("value display left to wrong state");
  a_name_step: assert property (
    disp_state_o == FPM_NAME && $past(disp_state_o) == FPM_NAME &&
      $changed(disp_idx_o) |->
      disp_idx_o == $past(disp_idx_o) + 4'h1 ||
      disp_idx_o == $past(disp_idx_o) - 4'h1)
    else $error("name index jumped");
  a_clear_pulse: assert property (
    counter_clear_o |-> s_tc_idle ##1 !counter_clear_o)
    else $error("bad counter clear pulse");
  a_gen_toggle: assert property (
    $changed(gen_run_o) |-> disp_state_o == FPM_TC && !counter_clear_o)
    else $error("generator toggled outside time code");
  a_level_range: assert property (
    s_level_shown |-> $signed(disp_value_o) >= LVL_MIN &&
      $signed(disp_value_o) <= LVL_MAX)
    else $error("level out of range");
  a_level_step: assert property (
    s_level_shown ##0 ($past(disp_state_o, 2) == FPM_VALUE &&
      $changed(disp_value_o)) |->
      (disp_value_o - $past(disp_value_o)) inside {8'h03, 8'hFD})
    else $error("level step not three");
  a_field_step: assert property (
    $changed(tc_field_o) |->
      tc_field_o == $past(tc_field_o) + 2'h1 || tc_field_o == FLD_HH)
    else $error("time code field skipped");
endmodule

// File: tb/fpm_operator.sv
`timescale 1ns/1ns
module fpm_operator
  import fpm_pkg::*;
(
  input  wire logic              clk_i,
  output logic      [NUM_SW-1:0] sw_o
);
  initial sw_o = '0;

  // holds a switch pattern for n cycles, changed just after an edge
  task automatic hold(input logic [NUM_SW-1:0] m, input int n);
    sw_o <= m;
    repeat (n) @(posedge clk_i);
  endtask
endmodule

// File: tb/tb_fpm_top.sv
`timescale 1ns/1ns
module tb_fpm_top
  import fpm_pkg::*;
;
  // ***********************************************************
  // signals
  // ***********************************************************
  localparam int              DB    = 4;
  localparam int              HT    = DB + 4;
  localparam logic [NUM_SW-1:0] M_SET = 7'h01;
  localparam logic [NUM_SW-1:0] M_DN  = 7'h02;
  localparam logic [NUM_SW-1:0] M_UP  = 7'h04;
  localparam logic [NUM_SW-1:0] M_RUN = 7'h08;
  localparam logic [NUM_SW-1:0] M_REF = 7'h70;
  logic              clk_i = 1'b0;
  logic              rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0]       haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0]        htrans_i, disp_state_o, tc_field_o;
  logic [2:0]        hsize_i;
  logic [3:0]        disp_idx_o;
  logic [7:0]        disp_value_o;
  logic              gen_run_o, counter_clear_o, remote_only_led_o;
  logic              clk_ref_press_o, pos_ref_press_o, frame_press_o;
  logic [NUM_SW-1:0] sw;
  logic [7:0]        tcm [4] = '{HH_MAX, MS_MAX, MS_MAX, FF_MAX};
  int                num_errors, cmp_count, clr_cnt, ref_cnt;

  always #50 clk_i = ~clk_i;

  fpm_top #(.DB_CYCLES(DB), .RPT_DELAY(20), .RPT_RATE(8)) DUT (
    .clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .set_sw_i(sw[SW_SET]), .down_sw_i(sw[SW_DN]), .up_sw_i(sw[SW_UP]),
    .run_sw_i(sw[SW_RUN]), .clk_ref_sw_i(sw[SW_CLK]),
    .pos_ref_sw_i(sw[SW_POS]), .frame_sw_i(sw[SW_FRM]), .disp_state_o,
    .disp_idx_o, .disp_value_o, .tc_field_o, .gen_run_o, .counter_clear_o,
    .remote_only_led_o, .clk_ref_press_o, .pos_ref_press_o, .frame_press_o);

  fpm_operator OP (.clk_i, .sw_o(sw));

  always @(posedge clk_i) begin
    if (counter_clear_o === 1'b1)
      clr_cnt++;
    ref_cnt += clk_ref_press_o + pos_ref_press_o + frame_press_o;
  end

  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h000000, a};
    hwrite_i <= w;
    hsize_i  <= 3'h2;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i   <= 1'b0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    check("resp", hresp_o, 0);
  endtask

  task automatic tap(input logic [NUM_SW-1:0] m);
    OP.hold(m, HT);
    OP.hold('0, HT);
  endtask

  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ***********************************************************
  // tests
  // ***********************************************************
  initial begin
    repeat (10000) @(posedge clk_i);
    num_errors++;
    conclude();
  end

  initial begin
    rst_i    <= 1'b1;
    hsel_i   <= 1'b0;
    haddr_i  <= '0;
    htrans_i <= 2'h0;
    hwrite_i <= 1'b0;
    hsize_i  <= 3'h2;
    hwdata_i <= '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    ahb(1'b0, CTRL_ADDR, 0);
    check("ctrl", rd, 0);
    ahb(1'b0, 8'h20, 0);
    check("unmapped", rd, 0);
    tap(M_SET);
    check("state", disp_state_o, FPM_NAME);
    check("idx", disp_idx_o, GEN_IDX);
    tap(M_DN);
    check("idx", disp_idx_o, IDX_LAST);
    tap(M_UP);
    tap(M_UP);
    check("idx", disp_idx_o, LEVEL_IDX);
    ahb(1'b0, STAT_ADDR, 0);
    check("status", rd, 32'h11);
    tap(M_SET);
    check("state", disp_state_o, FPM_VALUE);
    for (int i = 1; i <= 4; i++) begin
      tap(M_UP);
      check("level", disp_value_o, (i < 4) ? i * 3 : 9);
    end
    tap(M_SET);
    check("state", disp_state_o, FPM_TC);
    ahb(1'b0, LEVEL_ADDR, 0);
    check("level", rd[7:0], LVL_MAX);
    tap(M_SET);
    check("idx", disp_idx_o, GEN_IDX);
    tap(M_UP);
    tap(M_SET);
    OP.hold(M_DN, 200);
    check("level", disp_value_o, 8'hE8);
    OP.hold('0, HT);
    tap(M_RUN);
    check("state", disp_state_o, FPM_TC);
    ahb(1'b0, LEVEL_ADDR, 0);
    check("level", rd[7:0], LVL_MAX);
    tap(M_SET);
    tap(M_SET);
    check("field", tc_field_o, FLD_HH);
    for (int i = 0; i < 4; i++) begin
      OP.hold(M_DN, HT);
      check("tc", disp_value_o, tcm[i]);
      OP.hold(M_DN | M_UP, HT);
      OP.hold('0, HT);
      check("field", tc_field_o, (i + 1) % 4);
    end
    tap(M_RUN);
    check("state", disp_state_o, FPM_TC);
    ahb(1'b0, PRESET_ADDR, 0);
    check("preset", rd, TC_RST);
    OP.hold(M_SET, DB - 1);
    OP.hold('0, HT);
    check("state", disp_state_o, FPM_TC);
    ahb(1'b1, CTRL_ADDR, 32'h2);
    ahb(1'b0, CTRL_ADDR, 0);
    check("ctrl", rd, 32'h2);
    tap(M_RUN);
    check("run", gen_run_o, 1'b1);
    tap(M_RUN);
    check("run", gen_run_o, 1'b0);
    check("clears", clr_cnt, 0);
    ahb(1'b1, CTRL_ADDR, 0);
    tap(M_RUN);
    check("clears", clr_cnt, 1);
    for (int i = 4; i < 7; i++)
      tap(NUM_SW'(1 << i));
    check("presses", ref_cnt, 3);
    ahb(1'b1, CTRL_ADDR, 32'h1);
    tap(M_SET);
    tap(7'h10);
    check("led", remote_only_led_o, 1'b1);
    check("state", disp_state_o, FPM_TC);
    check("presses", ref_cnt, 3);
    OP.hold(M_REF, HT + 4);
    OP.hold('0, HT);
    check("led", remote_only_led_o, 1'b0);
    ahb(1'b0, CTRL_ADDR, 0);
    check("ctrl", rd, 0);
    tap(M_SET);
    check("state", disp_state_o, FPM_NAME);
    tap(M_RUN);
    ahb(1'b1, CTRL_ADDR, 32'h4);
    tap(M_SET);
    check("idx", disp_idx_o, LEVEL_IDX);
    conclude();
  end
endmodule

bind fpm_top fpm_top_monitor #(.DB_CYCLES(DB_CYCLES)) MON (
  .clk_i, .rst_i, .clk_ref_sw_i, .pos_ref_sw_i, .frame_sw_i,
  .disp_state_o, .disp_idx_o, .disp_value_o, .tc_field_o, .gen_run_o,
  .counter_clear_o, .remote_only_led_o, .clk_ref_press_o,
  .pos_ref_press_o, .frame_press_o);
